// File: spmp_consts.svh
// Purpose: Shared constants of the serial peripheral port.
// Assumes: Core clock of 10 MHz.
// Notes:   Definitions only.
`ifndef SPMP_CONSTS_SVH
`define SPMP_CONSTS_SVH

// ****************************************************************
// Widths and sizes
// ****************************************************************
`define SPMP_DATA_W     8
`define SPMP_FIFO_DEPTH 4
`define SPMP_BITS       4'h8
`define SPMP_DIV_W      11

// ****************************************************************
// Timing and reset values
// ****************************************************************
// Half period of the master clock is this base shifted by the rate field.
`define SPMP_HALF_BASE  11'h008
// Pin vector order is {ss_n, miso, mosi, sck}; select rests deselected.
`define SPMP_PIN_RST    4'h8
`define SPMP_PIN_SCK    0
`define SPMP_PIN_MOSI   1
`define SPMP_PIN_MISO   2
`define SPMP_PIN_SS     3

`endif

// File: spmp_pkg.sv
// Purpose: Types of the serial peripheral port.
// Assumes: Constants come from spmp_consts.svh.
// Notes:   Nothing here is imported; users write spmp_pkg::name.
package spmp_pkg;

  // ****************************************************************
  // Software visible fields
  // ****************************************************************
  typedef struct packed {
    logic       port_irq_enable;
    logic       port_enable;
    logic       master_select;
    logic       clock_polarity;
    logic       clock_phase;
    logic [2:0] rate_select;
  } spmp_ctl_s;

  typedef struct packed {
    logic output_disable;
    logic select_sw_manage;
    logic select_internal_level;
  } spmp_csr_s;

  typedef struct packed {
    logic xfer_done_flag;
    logic write_coll_flag;
    logic overrun_flag;
    logic mode_fault_flag;
  } spmp_flags_s;

  // ****************************************************************
  // Pin drive and engine state
  // ****************************************************************
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spmp_pins_s;

  typedef enum logic [1:0] {ST_IDLE, ST_PEND, ST_SHIFT} spmp_st_e;

endpackage

// File: spmp_port.sv
// Contract
// - Master drives SCK with programmed rate, polarity, phase.
// - Three-bit rate field sets master clock frequency.
// - SCK idles at polarity; peers share mode.
// - Low select clears master and enable bits.
// - Master data write loads and shifts MSB first.
// - Completion sets flag and raises enabled interrupt.
// - Status access then data read, or slave data write, clears flag.
// - Data writes ignored while flag set, unread.
// - Slave takes its clock from SCK pin.
// - Slave data write loads, shifts on master clock.
// - Slave echoes last received byte when unloaded.
// - Port runs in wait; events wake core.
// - Halt freezes port; extra bytes cause overrun.
// - Slave completion wakes from halt; overrun tracked.
// - Halt wake needs select low at entry.
// - Software select management uses internal bit.
// - Completion with flag set raises overrun.
// - Select low in master sets mode fault.
// - Received byte copied to read buffer.
//
// Purpose: Serial peripheral port, master or slave, with receive FIFO.
// Assumes: Pins arrive asynchronously and pass a three-stage synchroniser.
// Notes:   Host access is by one-cycle strobes; no register bus.
`timescale 1ns/1ns
`include "spmp_consts.svh"

// ****************************************************************
// Receive FIFO
// ****************************************************************
module spmp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [CW-1:0]       cnt;
    logic                full;
    logic                nonempty;
  } spmp_fifo_s;

  spmp_fifo_s f_q;
  spmp_fifo_s f_d;
  logic       push;
  logic       pop;

  // Pointers wrap at the depth, which need not be a power of two.
  always_comb
  begin
    f_d  = f_q;
    push = in_valid && !f_q.full;
    pop  = out_ready && f_q.nonempty;
    if (push)
    begin
      f_d.mem[f_q.wr] = in_data;
      f_d.wr = (f_q.wr == AW'(D - 1)) ? '0 : f_q.wr + 1'b1;
    end
    if (pop)
      f_d.rd = (f_q.rd == AW'(D - 1)) ? '0 : f_q.rd + 1'b1;
    f_d.cnt      = f_q.cnt + CW'(push) - CW'(pop);
    f_d.full     = (f_d.cnt == CW'(D));
    f_d.nonempty = (f_d.cnt != '0);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      f_q <= '0;
    else
      f_q <= f_d;
  end

  assign in_ready  = !f_q.full;
  assign out_valid = f_q.nonempty;
  assign out_data  = f_q.mem[f_q.rd];
endmodule

// ****************************************************************
// Port top
// ****************************************************************
module spmp_port (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // Host strobes
  input  wire logic                    ctl_wr,
  input  wire spmp_pkg::spmp_ctl_s     ctl_wdata,
  input  wire logic                    csr_wr,
  input  wire spmp_pkg::spmp_csr_s     csr_wdata,
  input  wire logic                    csr_rd,
  input  wire logic                    data_wr,
  input  wire logic [`SPMP_DATA_W-1:0] data_wdata,
  input  wire logic                    data_rd,
  // Core state
  input  wire logic                    cpu_int_mask,
  input  wire logic                    halt_mode,
  // Readback
  output spmp_pkg::spmp_ctl_s          ctl_q,
  output spmp_pkg::spmp_csr_s          csr_q,
  output spmp_pkg::spmp_flags_s        flags_q,
  output logic [`SPMP_DATA_W-1:0]      data_rdata,
  output logic                         busy,
  // Events
  output logic                         irq_req,
  output logic                         halt_wake,
  // Serial pins
  input  wire logic                    sck_in,
  output logic                         sck_out,
  output logic                         sck_oe,
  input  wire logic                    mosi_in,
  output logic                         mosi_out,
  output logic                         mosi_oe,
  input  wire logic                    miso_in,
  output logic                         miso_out,
  output logic                         miso_oe,
  input  wire logic                    ss_n_in,
  // Received byte stream
  output logic                         rx_valid,
  output logic [`SPMP_DATA_W-1:0]      rx_data,
  input  wire logic                    rx_ready
);
  typedef struct packed {
    spmp_pkg::spmp_ctl_s        ctl;
    spmp_pkg::spmp_csr_s        csr;
    spmp_pkg::spmp_flags_s      flags;
    spmp_pkg::spmp_pins_s       pins;
    spmp_pkg::spmp_st_e         st;
    logic [`SPMP_DATA_W-1:0]    sr;
    logic [`SPMP_DATA_W-1:0]    rdbuf;
    logic [3:0]                 bitcnt;
    logic [`SPMP_DIV_W-1:0]     div;
    logic [2:0][3:0]            sy;
    logic [3:0]                 filt;
    logic                       sel_prev;
    logic                       done_armed;
    logic                       fault_armed;
    logic                       coll_armed;
    logic                       halt_prev;
    logic                       halt_sel;
    logic                       push;
    logic                       irq;
    logic                       wake;
    logic                       busy;
  } spmp_state_s;

  spmp_state_s            s_q;
  spmp_state_s            s_d;
  logic                   fifo_ready;
  logic                   sel_low;
  logic                   slave_on;
  logic                   edge_ev;
  logic                   new_lvl;
  logic                   lead_ev;
  logic                   sample_ev;
  logic                   launch_ev;
  logic                   in_bit;
  logic [3:0]             cnt_nx;
  logic                   host_ok;
  logic [`SPMP_DIV_W-1:0] half_cnt;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d       = s_q;
    s_d.push  = 1'b0;
    host_ok   = !halt_mode;
    // Three-stage synchroniser; a level counts once stages two and three agree.
    s_d.sy[0] = {ss_n_in, miso_in, mosi_in, sck_in};
    s_d.sy[1] = s_q.sy[0];
    s_d.sy[2] = s_q.sy[1];
    for (int i = 0; i < 4; i++)
    begin
      if (s_q.sy[2][i] == s_q.sy[1][i])
        s_d.filt[i] = s_q.sy[2][i];
    end
    // Internal bit replaces the pin under software management.
    sel_low  = s_q.csr.select_sw_manage ? !s_q.csr.select_internal_level
                                        : !s_q.filt[`SPMP_PIN_SS];
    slave_on = s_q.ctl.port_enable && !s_q.ctl.master_select && sel_low;
    half_cnt = `SPMP_HALF_BASE << s_q.ctl.rate_select;

    // Edge source: own divider in master, synchronised pin in slave.
    edge_ev = 1'b0;
    new_lvl = s_q.pins.sck_o;
    if (s_q.st == spmp_pkg::ST_SHIFT && !halt_mode)
    begin
      s_d.div = s_q.div + 1'b1;
      if (s_q.div == half_cnt - 1'b1)
      begin
        s_d.div = '0;
        edge_ev = 1'b1;
        new_lvl = !s_q.pins.sck_o;
      end
    end
    else if (slave_on)
    begin
      edge_ev = s_d.filt[`SPMP_PIN_SCK] != s_q.filt[`SPMP_PIN_SCK];
      new_lvl = s_d.filt[`SPMP_PIN_SCK];
    end
    lead_ev   = edge_ev && (new_lvl != s_q.ctl.clock_polarity);
    sample_ev = s_q.ctl.clock_phase ? (edge_ev && !lead_ev) : lead_ev;
    launch_ev = edge_ev && !sample_ev;
    in_bit    = s_q.ctl.master_select ? s_q.filt[`SPMP_PIN_MISO]
                                      : s_q.filt[`SPMP_PIN_MOSI];
    cnt_nx    = s_q.bitcnt + 4'(sample_ev);

    // Shift MSB first: sample edge shifts in, launch edge drives out.
    if (sample_ev)
    begin
      s_d.sr     = {s_q.sr[`SPMP_DATA_W-2:0], in_bit};
      s_d.bitcnt = cnt_nx;
    end
    if (launch_ev)
    begin
      s_d.pins.mosi_o = s_q.sr[`SPMP_DATA_W-1];
      s_d.pins.miso_o = s_q.sr[`SPMP_DATA_W-1];
    end
    if (s_q.st == spmp_pkg::ST_SHIFT)
      s_d.pins.sck_o = new_lvl;
    else
      s_d.pins.sck_o = s_q.ctl.clock_polarity;

    // A deselected slave restarts its byte; phase 0 presents MSB on select.
    s_d.sel_prev = slave_on;
    if (!slave_on && s_q.st == spmp_pkg::ST_IDLE)
      s_d.bitcnt = '0;
    if (slave_on && !s_q.sel_prev && !s_q.ctl.clock_phase)
      s_d.pins.miso_o = s_q.sr[`SPMP_DATA_W-1];

    // Host side; the core is stopped in halt so accesses are ignored.
    if (host_ok && (csr_rd || csr_wr))
    begin
      if (s_q.flags.xfer_done_flag)
        s_d.done_armed = 1'b1;
      if (s_q.flags.mode_fault_flag)
        s_d.fault_armed = 1'b1;
      if (s_q.flags.write_coll_flag)
        s_d.coll_armed = 1'b1;
    end
    if (host_ok && csr_rd)
      s_d.flags.overrun_flag = 1'b0;
    if (host_ok && csr_wr)
      s_d.csr = csr_wdata;
    if (host_ok && ctl_wr)
    begin
      s_d.ctl = ctl_wdata;
      if (s_q.fault_armed)
      begin
        s_d.flags.mode_fault_flag = 1'b0;
        s_d.fault_armed = 1'b0;
      end
    end
    if (host_ok && (data_rd || data_wr) && s_q.coll_armed)
    begin
      s_d.flags.write_coll_flag = 1'b0;
      s_d.coll_armed = 1'b0;
    end
    if (host_ok && s_q.done_armed
        && (data_rd || (data_wr && !s_q.ctl.master_select)))
    begin
      s_d.flags.xfer_done_flag = 1'b0;
      s_d.done_armed = 1'b0;
    end
    if (host_ok && data_wr && (!s_q.flags.xfer_done_flag || s_q.done_armed))
    begin
      if (s_q.busy)
        s_d.flags.write_coll_flag = 1'b1;
      else
      begin
        s_d.sr          = data_wdata;
        s_d.pins.mosi_o = data_wdata[`SPMP_DATA_W-1];
        s_d.pins.miso_o = data_wdata[`SPMP_DATA_W-1];
        if (s_q.ctl.master_select && s_q.ctl.port_enable)
          s_d.st = spmp_pkg::ST_PEND;
      end
    end

    // Master waits for FIFO room so no received byte is lost.
    if (s_q.st == spmp_pkg::ST_PEND && fifo_ready && !halt_mode)
    begin
      s_d.st     = spmp_pkg::ST_SHIFT;
      s_d.div    = '0;
      s_d.bitcnt = '0;
    end

    // Byte complete: master after its eighth trailing edge, slave on eighth sample.
    if (cnt_nx == `SPMP_BITS && (s_q.ctl.master_select ? (edge_ev && !lead_ev) : sample_ev))
    begin
      s_d.push   = 1'b1;
      s_d.bitcnt = '0;
      s_d.st     = spmp_pkg::ST_IDLE;
      if (s_q.flags.xfer_done_flag)
        s_d.flags.overrun_flag = 1'b1;
      else
        s_d.rdbuf = s_d.sr;
      s_d.flags.xfer_done_flag = 1'b1;
      s_d.done_armed = 1'b0;
    end

    // Select pulled low under master mode is a fault and drops master.
    if (s_q.ctl.master_select && s_q.ctl.port_enable && sel_low)
    begin
      s_d.flags.mode_fault_flag = 1'b1;
      s_d.ctl.master_select     = 1'b0;
      s_d.ctl.port_enable       = 1'b0;
      s_d.st                    = spmp_pkg::ST_IDLE;
      s_d.bitcnt                = '0;
    end

    // Pin enables follow the mode; output disable frees the data pin.
    s_d.pins.sck_oe  = s_d.ctl.port_enable && s_d.ctl.master_select;
    s_d.pins.mosi_oe = s_d.pins.sck_oe && !s_d.csr.output_disable;
    s_d.pins.miso_oe = s_d.ctl.port_enable && !s_d.ctl.master_select && sel_low
                       && !s_d.csr.output_disable;
    s_d.busy = (s_d.st != spmp_pkg::ST_IDLE) || (s_d.bitcnt != '0);

    // Events; select level is caught at halt entry for the wake path.
    s_d.halt_prev = halt_mode;
    if (halt_mode && !s_q.halt_prev)
      s_d.halt_sel = sel_low;
    s_d.irq  = s_d.ctl.port_irq_enable && !cpu_int_mask
               && (|{s_d.flags.xfer_done_flag, s_d.flags.overrun_flag,
                     s_d.flags.mode_fault_flag});
    s_d.wake = halt_mode && s_d.halt_sel && s_d.ctl.port_irq_enable
               && s_d.flags.xfer_done_flag;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_q      <= '0;
      // Stages rest at the idle pin levels so no false select follows reset.
      s_q.sy   <= {3{`SPMP_PIN_RST}};
      s_q.filt <= `SPMP_PIN_RST;
    end
    else
      s_q <= s_d;
  end

  spmp_fifo #(
    .W (`SPMP_DATA_W),
    .D (`SPMP_FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (s_q.push),
    .in_data   (s_q.rdbuf),
    .in_ready  (fifo_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  // Outputs other than the receive stream come straight from the state register.
  assign ctl_q      = s_q.ctl;
  assign csr_q      = s_q.csr;
  assign flags_q    = s_q.flags;
  assign data_rdata = s_q.rdbuf;
  assign busy       = s_q.busy;
  assign irq_req    = s_q.irq;
  assign halt_wake  = s_q.wake;
  assign sck_out    = s_q.pins.sck_o;
  assign sck_oe     = s_q.pins.sck_oe;
  assign mosi_out   = s_q.pins.mosi_o;
  assign mosi_oe    = s_q.pins.mosi_oe;
  assign miso_out   = s_q.pins.miso_o;
  assign miso_oe    = s_q.pins.miso_oe;
endmodule

// File: spmp_port_checker.sv
// Purpose: Concurrent checks on the ports of the serial port top.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to spmp_port from the testbench file.
`timescale 1ns/1ns
module spmp_port_checker (
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  // Host side
  input wire logic                  ctl_wr,
  input wire logic                  csr_wr,
  input wire logic                  csr_rd,
  input wire logic                  data_wr,
  input wire logic [7:0]            data_wdata,
  input wire logic                  data_rd,
  input wire logic                  cpu_int_mask,
  input wire logic                  halt_mode,
  input wire spmp_pkg::spmp_ctl_s   ctl_q,
  input wire spmp_pkg::spmp_csr_s   csr_q,
  input wire spmp_pkg::spmp_flags_s flags_q,
  input wire logic                  busy,
  input wire logic                  irq_req,
  // Pins and stream
  input wire logic                  sck_out,
  input wire logic                  sck_oe,
  input wire logic                  mosi_out,
  input wire logic                  ss_n_in,
  input wire logic                  rx_valid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic armed_q;
  logic armed_d;
  wire  mst = ctl_q.master_select && ctl_q.port_enable;

  // A status access while the done flag stands arms the clearing data access.
  always_comb armed_d = flags_q.xfer_done_flag && (armed_q || ((csr_rd || csr_wr) && !halt_mode));
  // Cleared in reset so a stale arm never lets a write through.
  always_ff @(posedge core_clk) armed_q <= rst_n ? armed_d : 1'h0;

  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence s_start;
    data_wr && !halt_mode && mst && !busy && !flags_q.xfer_done_flag && !rx_valid;
  endsequence
  sequence s_sel_low;
    (mst && !csr_q.select_sw_manage && !ss_n_in) ##1 (!csr_q.select_sw_manage && !ss_n_in) [*3];
  endsequence

  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_sck_idle;
    mst && !busy && !$past(busy) && $stable(ctl_q) |-> sck_out == ctl_q.clock_polarity;
  endproperty
  property p_start;
    s_start |=> busy && mosi_out == $past(data_wdata[7]);
  endproperty
  property p_wr_inhibit;
    data_wr && mst && !busy && flags_q.xfer_done_flag && !armed_q && !csr_rd |=> !busy;
  endproperty
  property p_irq;
    $rose(flags_q.xfer_done_flag) && ctl_q.port_irq_enable && !cpu_int_mask |-> ##[0:1] irq_req;
  endproperty
  property p_flag_clr;
    data_rd && armed_q && !halt_mode && !busy |=> !flags_q.xfer_done_flag;
  endproperty
  property p_mode_fault;
    s_sel_low |-> ##[0:3] (flags_q.mode_fault_flag && !ctl_q.master_select);
  endproperty
  property p_ovr_cause;
    $rose(flags_q.overrun_flag) |-> $past(flags_q.xfer_done_flag);
  endproperty
  property p_halt_freeze;
    halt_mode |=> $stable(ctl_q) && $stable(csr_q);
  endproperty
  property p_slave_clk;
    ctl_q.port_enable && !ctl_q.master_select && $stable(ctl_q) |-> !sck_oe;
  endproperty

  a_sck_idle: assert property (p_sck_idle)
    else $error("serial clock not at idle level");
  a_start: assert property (p_start)
    else $error("master transfer did not start with the top bit");
  a_wr_inhibit: assert property (p_wr_inhibit)
    else $error("data write taken while done flag stood");
  a_irq: assert property (p_irq)
    else $error("interrupt request missing");
  a_flag_clr: assert property (p_flag_clr)
    else $error("done flag not cleared");
  a_mode_fault: assert property (p_mode_fault)
    else $error("mode fault not raised");
  a_ovr_cause: assert property (p_ovr_cause)
    else $error("overrun without standing done flag");
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("settings changed in halt");
  a_slave_clk: assert property (p_slave_clk)
    else $error("slave drives the serial clock");
endmodule

// File: spmp_peer.sv
// Purpose: Far side of the serial link, acting as master or slave.
// Assumes: Half period of 400 ns when it makes the clock.
// Notes:   Released data lines show the inverse of the last bit.
`timescale 1ns/1ns
module spmp_peer (
  // Mode
  input  wire logic role_m,
  input  wire logic pol,
  input  wire logic pha,
  input  wire logic sel,
  // Link
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  output logic      miso_o
);
  logic [7:0] sr;
  logic       q;
  logic       lvl;
  logic       act;

  // Clock rests at the polarity level outside frames.
  assign sck_o  = pol ^ lvl;
  assign act    = role_m ? !ss_n_o : sel;
  // An inverted stale bit keeps a released line from passing by luck.
  assign mosi_o = (role_m && act) ? q : !q;
  assign miso_o = (!role_m && act) ? q : !q;

  initial
  begin
    sr     = 8'h00;
    q      = 1'h0;
    lvl    = 1'h0;
    ss_n_o = 1'h1;
  end

  // Sample edge shifts in, launch edge shows the new top bit.
  always @(sck_i)
    if (act)
    begin
      if ((sck_i != pol) ^ pha)
        sr = {sr[6:0], role_m ? miso_i : mosi_i};
      else
        q = sr[7];
    end

  task load(input logic [7:0] b);
    sr = b;
    q  = b[7];
  endtask

  // One framed byte; select drops between bytes for phase 0.
  task xfer(input logic [7:0] b);
    load(b);
    ss_n_o = 1'h0;
    #800;
    repeat (16)
    begin
      lvl = !lvl;
      #400;
    end
    #400;
    ss_n_o = 1'h1;
  endtask
endmodule

// File: testbench.sv
// Purpose: Self-checking bench for the serial port top.
// Assumes: 100 ns core clock, 800 ns link clock from the peer.
// Notes:   Bytes stay in the receive buffer until it refuses.
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [2:0] rate;
    logic       pol;
    logic       pha;
    logic       ie;
    logic       msk;
    logic [7:0] tx;
    logic [7:0] rep;
  } spmp_row_s;

  logic core_clk, rst_n, ctl_wr, csr_wr, csr_rd, data_wr, data_rd;
  logic cpu_int_mask, halt_mode, rx_ready, tb_ss_n, peer_sel, peer_m, peer_pol, peer_pha;
  logic busy, irq_req, halt_wake, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic rx_valid, sck_prev;
  logic [7:0] data_wdata, data_rdata, rx_data;
  spmp_pkg::spmp_ctl_s   ctl_wdata, ctl_q;
  spmp_pkg::spmp_csr_s   csr_wdata, csr_q;
  spmp_pkg::spmp_flags_s flags_q;
  wire p_sck, p_ss_n, p_mosi, p_miso;
  wire sck_w  = sck_oe ? sck_out : p_sck;
  wire mosi_w = mosi_oe ? mosi_out : p_mosi;
  wire miso_w = miso_oe ? miso_out : p_miso;
  wire ss_w   = p_ss_n & tb_ss_n;
  int n_fail, n_checks, cnt, half;
  spmp_row_s rows [4] = '{'{3'h7, 1'h0, 1'h0, 1'h1, 1'h0, 8'h96, 8'h3a},
                          '{3'h1, 1'h0, 1'h1, 1'h1, 1'h1, 8'h81, 8'h7e},
                          '{3'h2, 1'h1, 1'h0, 1'h0, 1'h0, 8'h01, 8'hc5},
                          '{3'h0, 1'h1, 1'h1, 1'h1, 1'h0, 8'hff, 8'h00}};

  spmp_port i_spmp_port (.*, .sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w), .ss_n_in(ss_w));
  spmp_peer i_spmp_peer (.role_m(peer_m), .pol(peer_pol), .pha(peer_pha), .sel(peer_sel),
    .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(p_sck), .ss_n_o(p_ss_n),
    .mosi_o(p_mosi), .miso_o(p_miso));

  initial
  begin
    core_clk = 1'h0;
    forever #50 core_clk = !core_clk;
  end

  // Cycles between master clock toggles, kept for the rate check.
  always @(posedge core_clk)
  begin
    cnt = cnt + 1;
    if (sck_out !== sck_prev)
      half = cnt;
    if (sck_out !== sck_prev)
      cnt = 0;
    sck_prev = sck_out;
  end

  // One strobe per call: 0 ctl, 1 csr write, 2 csr read, 3 data write, 4 data read.
  task host(input int op, input logic [7:0] v);
    @(negedge core_clk);
    ctl_wdata  = v;
    csr_wdata  = v[2:0];
    data_wdata = v;
    {ctl_wr, csr_wr, csr_rd, data_wr, data_rd} = 5'h10 >> op;
    @(negedge core_clk);
    {ctl_wr, csr_wr, csr_rd, data_wr, data_rd} = 5'h00;
  endtask

  task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bounded wait for the done flag; a miss shows in the checks after it.
  task waitf(input int lim);
    for (int i = 0; i < lim && flags_q.xfer_done_flag !== 1'h1; i++)
      @(negedge core_clk);
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #6000000;
    n_fail++;
    results();
  end

  initial
  begin
    {rst_n, ctl_wr, csr_wr, csr_rd, data_wr, data_rd, cpu_int_mask, halt_mode} = 8'h00;
    {rx_ready, tb_ss_n, peer_sel, peer_m, peer_pol, peer_pha} = 6'h00;
    {ctl_wdata, csr_wdata, data_wdata} = 19'h00000;
    repeat (12) @(negedge core_clk);
    rst_n = 1'h1;
    @(negedge core_clk);
    chk("reset", 12'h000, {flags_q, busy, irq_req, ctl_q.master_select, ctl_q.port_enable});
    repeat (3) @(negedge core_clk);
    // Select pin held low throughout: software management must hide it.
    foreach (rows[k])
    begin
      {peer_pol, peer_pha, cpu_int_mask} = {rows[k].pol, rows[k].pha, rows[k].msk};
      host(1, 8'h03);
      host(0, {rows[k].ie, 2'h0, rows[k].pol, rows[k].pha, rows[k].rate});
      host(0, {rows[k].ie, 2'h3, rows[k].pol, rows[k].pha, rows[k].rate});
      i_spmp_peer.load(rows[k].rep);
      peer_sel = 1'h1;
      host(3, rows[k].tx);
      waitf(20000);
      peer_sel = 1'h0;
      chk("irq", rows[k].ie & !rows[k].msk, irq_req);
      chk("half", 12'h008 << rows[k].rate, half);
      chk("idle", rows[k].pol, sck_out);
      chk("peer", rows[k].tx, i_spmp_peer.sr);
      chk("rdata", rows[k].rep, data_rdata);
      host(3, 8'h55);
      chk("inhibit", 12'h000, busy);
      host(2, 8'h00);
      host(4, 8'h00);
      chk("flag", 12'h000, flags_q.xfer_done_flag);
    end
    // Receive buffer is full: the next start must wait for room.
    peer_sel = 1'h1;
    i_spmp_peer.load(8'h5e);
    host(3, 8'ha7);
    repeat (300) @(negedge core_clk);
    chk("stall", 12'h000, flags_q.xfer_done_flag);
    rx_ready = 1'h1;
    foreach (rows[k])
    begin
      chk("rx", {1'h1, rows[k].rep}, {rx_valid, rx_data});
      @(negedge core_clk);
    end
    waitf(400);
    peer_sel = 1'h0;
    chk("late", 8'h5e, data_rdata);
    host(2, 8'h00);
    host(4, 8'h00);
    host(1, 8'h00);
    repeat (8) @(negedge core_clk);
    chk("fault", 12'h001, {ctl_q.port_enable, ctl_q.master_select, flags_q.mode_fault_flag});
    // Slave: peer makes the clock, polarity 1, phase 0.
    {tb_ss_n, peer_m, peer_pol, peer_pha} = 4'he;
    host(1, 8'h00);
    host(0, 8'hd0);
    host(3, 8'h5a);
    i_spmp_peer.xfer(8'hc3);
    waitf(50);
    chk("s_tx", 8'h5a, i_spmp_peer.sr);
    chk("s_rx", 8'hc3, data_rdata);
    fork
      i_spmp_peer.xfer(8'h3c);
      begin
        #500;
        @(negedge core_clk);
        halt_mode = 1'h1;
      end
    join
    host(0, 8'h00);
    repeat (8) @(negedge core_clk);
    chk("frozen", 8'hd0, ctl_q);
    chk("wake", 12'h001, halt_wake);
    chk("echo", 8'hc3, i_spmp_peer.sr);
    chk("ovr", 12'h001, flags_q.overrun_flag);
    chk("kept", 8'hc3, data_rdata);
    halt_mode = 1'h0;
    host(2, 8'h00);
    chk("ovr_clr", 12'h000, flags_q.overrun_flag);
    host(4, 8'h00);
    chk("s_flag", 12'h000, flags_q.xfer_done_flag);
    // Still a slave after the wake, so one extra byte returns the byte taken in halt.
    i_spmp_peer.xfer(8'h69);
    waitf(50);
    chk("extra", 8'h69, data_rdata);
    chk("echo2", 8'h3c, i_spmp_peer.sr);
    results();
  end
endmodule

bind spmp_port spmp_port_checker i_spmp_port_checker (.core_clk, .rst_n, .ctl_wr, .csr_wr,
  .csr_rd, .data_wr, .data_wdata, .data_rd, .cpu_int_mask, .halt_mode, .ctl_q, .csr_q,
  .flags_q, .busy, .irq_req, .sck_out, .sck_oe, .mosi_out, .ss_n_in, .rx_valid);
